/* File: rmbs_ram_map.sv */
`timescale 1ns/1ps
module rmbs_ram_map import rmbs_pkg::*; #(
	parameter int BANKS = BANK_COUNT
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [9:0] mem_addr,
	input wire logic mem_wr,
	input wire logic [3:0] mem_wdata,
	output logic [3:0] mem_rdata,
	input wire logic scr_en,
	input wire logic scr_wr,
	input wire logic [3:0] scr_idx,
	input wire logic [3:0] scr_wdata,
	output logic [3:0] scr_rdata,
	input wire logic call_push,
	input wire logic [13:0] pc_in,
	input wire logic branch_condition_flag_in,
	input wire logic arithmetic_overflow_bit_in,
	input wire logic ret_pop,
	input wire logic ret_is_int,
	output logic [13:0] pc_out,
	output logic branch_condition_flag_out,
	output logic arithmetic_overflow_bit_out,
	output logic pc_restore,
	output logic flags_restore,
	output logic [9:0] stack_top_pointer,
	output logic [1:0] data_bank_select,
	output logic [LCD_DIGITS*4-1:0] lcd_seg
);
	logic [3:0] flat_mem [0:MEM_WORDS-1];
	logic [3:0] bank_mem [0:BANKS*BANKED_DIGITS-1];
	logic [5:0] sp_low_r;
	logic [5:0] sp_low_nxt;
	logic [1:0] bank_r;
	logic [3:0] rdata_nxt;
	logic [15:0] pop_frame;
	logic [LCD_DIGITS*4-1:0] lcd_digits;

	wire in_bank_reg = (mem_addr == SFR_BANK_ADDR);
	wire in_banked = (mem_addr >= DATA_BASE) && (mem_addr <= BANKED_LAST);
	wire in_flat = ((mem_addr >= SCR_BASE) && (mem_addr <= LCD_LAST)) || (mem_addr >= COMMON_BASE);
	wire do_pop = ret_pop && !call_push;
	wire [1:0] bank_eff = (32'(bank_r) >= BANKS) ? 2'h0 : bank_r;
	wire [10:0] bank_idx = 11'(bank_eff) * 11'(BANKED_DIGITS) + 11'(mem_addr - DATA_BASE);
	wire [9:0] scr_addr = SCR_BASE | {6'h00, scr_idx};
	wire [15:0] push_frame = {arithmetic_overflow_bit_in, branch_condition_flag_in, pc_in};
	wire [5:0] pop_low = sp_low_r + SP_STEP;

	// A push wins over a pop in the same cycle; the pop is dropped.
	assign sp_low_nxt = call_push ? sp_low_r - SP_STEP : do_pop ? pop_low : sp_low_r;
	// Only the low six bits move, so sixteen frames wrap inside the stack page.
	assign stack_top_pointer = {STACK_PAGE, sp_low_r};
	assign data_bank_select = bank_r;
	assign rdata_nxt = in_bank_reg ? {2'h0, bank_r} :
		in_banked ? bank_mem[bank_idx] :
		in_flat ? flat_mem[mem_addr] : 4'h0;

	genvar k;
	generate
		for (k = 0; k < FRAME_DIGITS; k = k + 1) begin : g_frame
			assign pop_frame[k*4 +: 4] = flat_mem[{STACK_PAGE, pop_low - 6'(FRAME_DIGITS - 1 - k)}];
		end
		for (k = 0; k < LCD_DIGITS; k = k + 1) begin : g_lcd
			assign lcd_digits[k*4 +: 4] = flat_mem[LCD_BASE + 10'(k)];
		end
	endgenerate

	// Storage has no reset: data memory powers up undefined.
	always_ff @(posedge mclk) begin
		if (mem_wr && in_flat) begin
			flat_mem[mem_addr] <= mem_wdata;
		end
		if (scr_en && scr_wr) begin
			flat_mem[scr_addr] <= scr_wdata;
		end
		if (call_push) begin
			for (int i = 0; i < FRAME_DIGITS; i++) begin
				flat_mem[{STACK_PAGE, sp_low_r - 6'(FRAME_DIGITS - 1 - i)}] <= push_frame[i*4 +: 4];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (mem_wr && in_banked) begin
			bank_mem[bank_idx] <= mem_wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sp_low_r <= SP_LOW_RST;
			bank_r <= BANK_RST;
		end else begin
			sp_low_r <= sp_low_nxt;
			if (mem_wr && in_bank_reg) begin
				bank_r <= mem_wdata[1:0];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mem_rdata <= 4'h0;
			scr_rdata <= 4'h0;
		end else begin
			mem_rdata <= rdata_nxt;
			if (scr_en) begin
				scr_rdata <= flat_mem[scr_addr];
			end
		end
	end

	// Flags are only refreshed on an interrupt return; a plain return leaves them alone.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pc_out <= 14'h0000;
			branch_condition_flag_out <= 1'h1;
			arithmetic_overflow_bit_out <= 1'h0;
			pc_restore <= 1'h0;
			flags_restore <= 1'h0;
		end else begin
			pc_restore <= do_pop;
			flags_restore <= do_pop && ret_is_int;
			if (do_pop) begin
				pc_out <= pop_frame[13:0];
			end
			if (do_pop && ret_is_int) begin
				branch_condition_flag_out <= pop_frame[14];
				arithmetic_overflow_bit_out <= pop_frame[15];
			end
		end
	end

	rmbs_lcd_drive #(
		.DIGITS(LCD_DIGITS)
	) u_lcd (
		.mclk(mclk),
		.rst(rst),
		.lcd_digits(lcd_digits),
		.lcd_seg(lcd_seg)
	);

	// Checker-only tracker of the last common-area write, used to prove bank independence.
	logic cmn_vld_r;
	logic [9:0] cmn_addr_r;
	logic [3:0] cmn_data_r;
	logic [1:0] cmn_bank_r;
	wire in_common = (mem_addr >= COMMON_BASE) && (mem_addr < STACK_BASE);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmn_vld_r <= 1'h0;
			cmn_addr_r <= 10'h000;
			cmn_data_r <= 4'h0;
			cmn_bank_r <= 2'h0;
		end else if (mem_wr && in_common) begin
			cmn_vld_r <= 1'h1;
			cmn_addr_r <= mem_addr;
			cmn_data_r <= mem_wdata;
			cmn_bank_r <= bank_r;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence push_then_pop;
		call_push ##1 (ret_pop && !call_push && !mem_wr);
	endsequence
	sequence push_then_int_pop;
		call_push ##1 (ret_pop && ret_is_int && !call_push && !mem_wr);
	endsequence
	sequence lcd_write_kept;
		(mem_wr && mem_addr == LCD_BASE && !call_push) ##1 !(mem_wr && mem_addr == LCD_BASE);
	endsequence
	sequence banked_write_reread;
		(mem_wr && in_banked) ##1 (mem_addr == $past(mem_addr) && !mem_wr && bank_r == $past(bank_r));
	endsequence
	sequence bank3_write;
		mem_wr && in_banked && bank_r == 2'h3;
	endsequence
	sequence common_reread_other_bank;
		cmn_vld_r && !mem_wr && mem_addr == cmn_addr_r && bank_r != cmn_bank_r;
	endsequence

	frame_top_saved_a: assert property (call_push |=> stack_top_pointer[9:6] == STACK_PAGE &&
		flat_mem[$past(stack_top_pointer)] ==
		{$past(arithmetic_overflow_bit_in), $past(branch_condition_flag_in), $past(pc_in[13:12])})
		else $error("push did not save the flags digit at the old stack top");
	sp_push_step_a: assert property (call_push |=> sp_low_r == $past(sp_low_r) - SP_STEP)
		else $error("push did not lower stack pointer by four");
	sp_pop_step_a: assert property (ret_pop && !call_push |=> sp_low_r == $past(sp_low_r) + SP_STEP)
		else $error("pop did not raise stack pointer by four");
	ret_pc_back_a: assert property (push_then_pop |=> pc_restore && pc_out == $past(pc_in, 2))
		else $error("return did not reload saved program counter");
	int_flags_back_a: assert property (push_then_int_pop |=> flags_restore &&
		branch_condition_flag_out == $past(branch_condition_flag_in, 2) &&
		arithmetic_overflow_bit_out == $past(arithmetic_overflow_bit_in, 2))
		else $error("interrupt return did not restore flags");
	sub_ret_flags_a: assert property (ret_pop && !ret_is_int && !call_push |=>
		!flags_restore && $stable(branch_condition_flag_out) && $stable(arithmetic_overflow_bit_out))
		else $error("subroutine return touched flags");
	bank_reg_wr_a: assert property (mem_wr && in_bank_reg |=> data_bank_select == $past(mem_wdata[1:0]))
		else $error("bank select not loaded");
	lcd_seg_follow_a: assert property (lcd_write_kept |=> lcd_seg[3:0] == $past(mem_wdata, 2))
		else $error("segment outputs do not follow display data");
	banked_reread_a: assert property (banked_write_reread |=> mem_rdata == $past(mem_wdata, 2))
		else $error("banked location lost its data");
	bank3_alias_a: assert property (bank3_write |-> bank_idx == 11'(mem_addr - DATA_BASE))
		else $error("bank three does not alias bank zero");
	common_area_a: assert property (common_reread_other_bank |=> mem_rdata == $past(cmn_data_r))
		else $error("common area depends on bank select");
	scratch_swap_a: assert property ((scr_en && scr_wr) ##1 (scr_en && !scr_wr && scr_idx == $past(scr_idx) &&
		!call_push) |=> scr_rdata == $past(scr_wdata, 2))
		else $error("scratch slot lost its data");
endmodule

/* File: rmbs_pkg.sv */
package rmbs_pkg;
	localparam logic [9:0] SFR_BANK_ADDR = 10'h03f;
	localparam logic [9:0] SCR_BASE = 10'h040;
	localparam logic [9:0] LCD_BASE = 10'h050;
	localparam logic [9:0] LCD_LAST = 10'h083;
	localparam logic [9:0] DATA_BASE = 10'h090;
	localparam logic [9:0] BANKED_LAST = 10'h25f;
	localparam logic [9:0] COMMON_BASE = 10'h260;
	localparam logic [9:0] STACK_BASE = 10'h3c0;
	localparam logic [3:0] STACK_PAGE = 4'hf;
	localparam logic [5:0] SP_LOW_RST = 6'h3f;
	localparam logic [5:0] SP_STEP = 6'h04;
	localparam logic [1:0] BANK_RST = 2'h0;
	localparam int SCR_SLOTS = 'h10;
	localparam int LCD_DIGITS = 'h34;
	localparam int BANKED_DIGITS = 'h1d0;
	localparam int BANK_COUNT = 'h3;
	localparam int FRAME_DIGITS = 'h4;
	localparam int MEM_WORDS = 'h400;
endpackage

/* File: rmbs_lcd_drive.sv */
`timescale 1ns/1ps
module rmbs_lcd_drive import rmbs_pkg::*; #(
	parameter int DIGITS = LCD_DIGITS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [DIGITS*4-1:0] lcd_digits,
	output logic [DIGITS*4-1:0] lcd_seg
);
	// Each bit drives one segment: one lights it, zero blanks it.
	genvar g;
	generate
		for (g = 0; g < DIGITS; g = g + 1) begin : g_digit
			// One register per digit keeps each process the sole writer of its own variable.
			logic [3:0] seg_r;
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					seg_r <= 4'h0;
				end else begin
					seg_r <= lcd_digits[g*4 +: 4];
				end
			end
			assign lcd_seg[g*4 +: 4] = seg_r;
		end
	endgenerate
endmodule

/* File: rmbs_cpu_model.sv */
`timescale 1ns/1ps
module rmbs_cpu_model (
	input wire logic mclk,
	input wire logic [3:0] mem_rdata,
	output logic [9:0] mem_addr,
	output logic mem_wr,
	output logic [3:0] mem_wdata,
	output logic call_push,
	output logic ret_pop,
	output logic ret_is_int,
	output logic [13:0] pc_in,
	output logic bcf,
	output logic aob
);
	initial begin
		{mem_addr, mem_wr, mem_wdata, call_push, ret_pop, ret_is_int, pc_in, bcf, aob} = '0;
	end
	// Released data is inverted so a stale value never passes for a fresh one.
	task automatic wr(input logic [9:0] a, input logic [3:0] d);
		@(posedge mclk);
		mem_addr <= a;
		mem_wr <= 1'b1;
		mem_wdata <= d;
		@(posedge mclk);
		mem_wr <= 1'b0;
		mem_wdata <= ~d;
	endtask
	task automatic rd(input logic [9:0] a, output logic [3:0] d);
		@(posedge mclk);
		mem_addr <= a;
		@(posedge mclk);
		#1 d = mem_rdata;
	endtask
	task automatic sel_bank(input logic [1:0] b);
		wr(10'h03f, {2'h0, b});
	endtask
	task automatic push(input logic [13:0] pc, input logic f, input logic c);
		@(posedge mclk);
		call_push <= 1'b1;
		pc_in <= pc;
		bcf <= f;
		aob <= c;
		@(posedge mclk);
		call_push <= 1'b0;
		pc_in <= ~pc;
	endtask
	// A return issued in the cycle right after a call, so the frame just written is read back.
	task automatic call_ret(input logic [13:0] pc, input logic f, input logic c, input logic i);
		push(pc, f, c);
		ret_pop <= 1'b1;
		ret_is_int <= i;
		@(posedge mclk);
		ret_pop <= 1'b0;
	endtask
	task automatic pop(input logic i);
		@(posedge mclk);
		ret_pop <= 1'b1;
		ret_is_int <= i;
		@(posedge mclk);
		ret_pop <= 1'b0;
	endtask
endmodule

/* File: rmbs_ram_map_tb_top.sv */
`timescale 1ns/1ps
module rmbs_ram_map_tb_top;
	logic mclk, rst, scr_en, scr_wr, mem_wr, call_push, ret_pop, ret_is_int, bcf, aob;
	logic bcf_o, aob_o, pc_restore, flags_restore;
	logic [3:0] scr_idx, scr_wdata, scr_rdata, mem_rdata, mem_wdata, d;
	logic [9:0] mem_addr, stack_top_pointer;
	logic [13:0] pc_in, pc_out;
	logic [1:0] data_bank_select;
	logic [207:0] lcd_seg;
	int bad_count = 0;
	int n_checks = 0;
	rmbs_ram_map dut (.mclk(mclk), .rst(rst), .mem_addr(mem_addr), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .scr_en(scr_en), .scr_wr(scr_wr),
		.scr_idx(scr_idx), .scr_wdata(scr_wdata), .scr_rdata(scr_rdata), .call_push(call_push),
		.pc_in(pc_in), .branch_condition_flag_in(bcf), .arithmetic_overflow_bit_in(aob),
		.ret_pop(ret_pop), .ret_is_int(ret_is_int), .pc_out(pc_out),
		.branch_condition_flag_out(bcf_o), .arithmetic_overflow_bit_out(aob_o),
		.pc_restore(pc_restore), .flags_restore(flags_restore),
		.stack_top_pointer(stack_top_pointer), .data_bank_select(data_bank_select), .lcd_seg(lcd_seg));
	rmbs_cpu_model cpu (.mclk(mclk), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .call_push(call_push), .ret_pop(ret_pop), .ret_is_int(ret_is_int),
		.pc_in(pc_in), .bcf(bcf), .aob(aob));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d errors=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
	initial begin
		rst = 1'b1;
		{scr_en, scr_wr, scr_idx, scr_wdata} = '0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		#1 chk(stack_top_pointer, 10'h3ff);
		chk({pc_out, bcf_o, aob_o, data_bank_select}, 18'h8);
		cpu.wr(10'h03f, 4'hf);
		cpu.rd(10'h03f, d);
		chk({d, data_bank_select}, 6'hf);
		for (int b = 0; b < 3; b++) begin
			cpu.sel_bank(b[1:0]);
			cpu.wr(10'h25f, 4'h5 + b[3:0]);
		end
		cpu.wr(10'h260, 4'hc);
		for (int b = 0; b < 4; b++) begin
			cpu.sel_bank(b[1:0]);
			cpu.rd(10'h25f, d);
			chk(d, (b == 3) ? 4'h5 : 4'h5 + b[3:0]);
			cpu.rd(10'h260, d);
			chk(d, 4'hc);
		end
		cpu.wr(10'h090, 4'hd);
		cpu.sel_bank(2'h0);
		cpu.rd(10'h090, d);
		chk(d, 4'hd);
		cpu.wr(10'h04f, 4'h9);
		@(posedge mclk);
		{scr_en, scr_wr, scr_idx, scr_wdata} <= {2'b11, 4'hf, 4'h6};
		@(posedge mclk);
		{scr_en, scr_wr, scr_wdata} <= {2'b10, 4'h9};
		#1 chk(scr_rdata, 4'h9);
		@(posedge mclk);
		scr_en <= 1'b0;
		#1 chk(scr_rdata, 4'h6);
		cpu.rd(10'h04f, d);
		chk(d, 4'h6);
		cpu.wr(10'h083, 4'ha);
		cpu.wr(10'h050, 4'h5);
		repeat (2) @(posedge mclk);
		#1 chk({lcd_seg[207:204], lcd_seg[3:0]}, 8'ha5);
		cpu.push(14'h2abc, 1'b0, 1'b1);
		#1 chk(stack_top_pointer, 10'h3fb);
		cpu.push(14'h1234, 1'b1, 1'b0);
		#1 chk(stack_top_pointer, 10'h3f7);
		for (int i = 0; i < 4; i++) begin
			cpu.rd(10'h3fc + i[9:0], d);
			chk(d, (32'haabc >> (4 * i)) & 32'hf);
		end
		cpu.pop(1'b0);
		#1 chk({pc_restore, flags_restore, pc_out, bcf_o, aob_o}, {2'b10, 14'h1234, 2'b10});
		chk(stack_top_pointer, 10'h3fb);
		cpu.pop(1'b1);
		#1 chk({pc_restore, flags_restore, pc_out, bcf_o, aob_o}, {2'b11, 14'h2abc, 2'b01});
		chk(stack_top_pointer, 10'h3ff);
		cpu.call_ret(14'h3c5a, 1'b1, 1'b1, 1'b1);
		#1 chk({pc_restore, flags_restore, pc_out, bcf_o, aob_o}, {2'b11, 14'h3c5a, 2'b11});
		cpu.call_ret(14'h05a3, 1'b0, 1'b0, 1'b0);
		#1 chk({pc_restore, flags_restore, pc_out, bcf_o, aob_o}, {2'b10, 14'h05a3, 2'b11});
		chk(stack_top_pointer, 10'h3ff);
		for (int i = 0; i < 16; i++) begin
			cpu.push(14'h0, 1'b0, 1'b0);
		end
		#1 chk(stack_top_pointer, 10'h3ff);
		cpu.wr(10'h3c0, 4'h7);
		cpu.rd(10'h3c0, d);
		chk(d, 4'h7);
		stop_test();
	end
endmodule
